// ### core/ebp_top.sv
`timescale 1ns/10ps
// Behaviour
// - Direction bit picks forward or reverse drive.
// - New direction takes effect next PWM cycle.
// - Lead switch happens 4 Tosc times prescale early.
// - Prescale 1, 4 or 16 from 2-bit field.
// - Modulated outputs stay inactive during lead.
// - Active pair off, opposite unmodulated output on.
// - Full bridge has no dead band.
// - Half bridge dead band from bits 6:0.
// - Bit 7 of delay register enables restart.
// - Source field picks fault or comparators.
// - Two 2-bit fields set shutdown pin states.
// - Period register sets PWM period.
// - Duty is duty register plus two bits.
// - Config field and polarity field shape outputs.
// - Timer runs when on; flag at period end.
// - Sleep freezes timer, state and pin levels.
// - Block simply runs on whatever clock arrives.
// - Clock failure sets flag, internal oscillator mode.
// - Reset makes pins inputs, registers defaults.
module ebp_top (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire ebp_pkg::ebp_bus_t bus,
   output logic [7:0] rdata,
   // Shutdown sources from outside the clock domain.
   input wire logic faultPin_n,
   input wire logic cmp1Out,
   input wire logic cmp2Out,
   // Power management.
   input wire logic sleepReq,
   input wire logic clkFail,
   output logic intOscMode,
   // Bridge pins.
   output ebp_pkg::ebp_pins_t pins
);

   ebp_pkg::ebp_state_t st_q; // Registered state.
   ebp_pkg::ebp_state_t st_d; // Next state.

   logic dbA; // Dead-banded drive for output a.
   logic dbB; // Dead-banded drive for output b.

   // Last prescaler count of one timer step for the prescale field.
   function automatic logic [5:0] preLast(input logic [1:0] ps);
      case (ps)
         2'h0: preLast = ebp_pkg::PRE_LAST_1;
         2'h1: preLast = ebp_pkg::PRE_LAST_4;
         default: preLast = ebp_pkg::PRE_LAST_16;
      endcase
   endfunction

   // Two low bits of the 10-bit count, taken from the prescaler.
   function automatic logic [1:0] fineBits(input logic [5:0] pre,
                                           input logic [1:0] ps);
      case (ps)
         2'h0: fineBits = pre[1:0];
         2'h1: fineBits = pre[3:2];
         default: fineBits = pre[5:4];
      endcase
   endfunction

   // True for either full-bridge configuration.
   function automatic logic isFull(input logic [1:0] cfg);
      isFull = (cfg == ebp_pkg::CFG_FWD) || (cfg == ebp_pkg::CFG_REV);
   endfunction

   // Drive level for a shutdown state field; 1x means released.
   function automatic logic shutLvl(input logic [1:0] f);
      shutLvl = (f == 2'h1);
   endfunction

   // Combinational views of the registered state.
   logic timerOn; // Period timer is running.
   logic [1:0] psField; // Prescale selector.
   logic [1:0] newCfg; // Configuration software asked for.
   logic stepEnd; // Last prescaler count of a timer step.
   logic periodEnd; // Last clock of the PWM period.
   logic leadPhase; // Direction change lead window.
   logic modAct; // Modulated output active.
   logic srcActive; // Selected shutdown source asserted.
   logic [2:0] srcSel; // Shutdown source selection.
   logic faultAct; // Fault pin asserted, after sync.
   logic halfMode; // Half bridge in effect.

   always_comb begin
      timerOn = st_q.tctrl[ebp_pkg::TCTRL_ON_BIT];
      psField = st_q.tctrl[1:0];
      newCfg = st_q.ctrl[ebp_pkg::CTRL_CFG_HI:ebp_pkg::CTRL_CFG_LO];
      stepEnd = timerOn && (st_q.pre >= preLast(psField));
      periodEnd = stepEnd && (st_q.timer == st_q.period);
      // The final timer step lasts 4 Tosc times prescale, so the lead
      // window is the whole step in which the timer equals the period.
      leadPhase = timerOn && (st_q.timer == st_q.period)
                  && isFull(st_q.cfg) && isFull(newCfg)
                  && (newCfg[1] != st_q.cfg[1]);
      modAct = {st_q.timer, fineBits(st_q.pre, psField)}
               < st_q.dutyLat;
      srcSel = st_q.shut[ebp_pkg::SHUT_SRC_LO +: 3];
      faultAct = !st_q.syncB[0];
      srcActive = (srcSel[2] && faultAct)
                  || (srcSel[0] && st_q.syncB[1])
                  || (srcSel[1] && st_q.syncB[2])
                  || (srcSel == 3'h3 && (st_q.syncB[1]
                                         || st_q.syncB[2]));
      halfMode = (st_q.cfg == ebp_pkg::CFG_HALF);
   end

   // Dead band for the non-inverted half-bridge output.
   ebp_deadband #(
      .DW(7)
   ) u_dbA (
      .core_clk(core_clk),
      .rst(rst),
      .hold(sleepReq),
      .delay(st_q.delay[6:0]),
      .sigIn(halfMode && modAct),
      .sigOut(dbA)
   );

   // Dead band for the complementary half-bridge output.
   ebp_deadband #(
      .DW(7)
   ) u_dbB (
      .core_clk(core_clk),
      .rst(rst),
      .hold(sleepReq),
      .delay(st_q.delay[6:0]),
      .sigIn(halfMode && !modAct),
      .sigOut(dbB)
   );

   // Next-state logic: timer, register writes, flags, shutdown, pins.
   always_comb begin
      logic [3:0] act;
      logic [3:0] lvl;
      logic [3:0] rel;
      logic shutNow;
      act = '0;
      lvl = '0;
      rel = '0;
      shutNow = 1'b0;
      st_d = st_q;
      st_d.rdata = '0;

      // Pin inputs pass two flip-flops; only the second stage is used.
      st_d.syncA = {clkFail, cmp2Out, cmp1Out, faultPin_n};
      st_d.syncB = st_q.syncA;

      // Reads answer in the next cycle, also during sleep.
      if (bus.rd) begin
         case (bus.addr)
            ebp_pkg::ADDR_CTRL: st_d.rdata = st_q.ctrl;
            ebp_pkg::ADDR_DUTY: st_d.rdata = st_q.duty;
            ebp_pkg::ADDR_PERIOD: st_d.rdata = st_q.period;
            ebp_pkg::ADDR_TCTRL: st_d.rdata = {5'h00, st_q.tctrl};
            ebp_pkg::ADDR_TIMER: st_d.rdata = st_q.timer;
            ebp_pkg::ADDR_DELAY: st_d.rdata = st_q.delay;
            ebp_pkg::ADDR_SHUT: st_d.rdata = st_q.shut;
            ebp_pkg::ADDR_FLAG1: begin
               st_d.rdata[ebp_pkg::FLAG1_TIMER_BIT] = st_q.timerFlag;
            end
            ebp_pkg::ADDR_FLAG2: begin
               st_d.rdata[ebp_pkg::FLAG2_OSCFAIL_BIT] = st_q.oscFailFlag;
            end
            ebp_pkg::ADDR_PINDIR: st_d.rdata = {4'h0, st_q.pinDir};
            default: st_d.rdata = '0;
         endcase
      end

      // In sleep nothing but the synchronisers and read data moves.
      if (!sleepReq) begin
         // Software writes come first so hardware sets win below.
         if (bus.wr) begin
            case (bus.addr)
               ebp_pkg::ADDR_CTRL: st_d.ctrl = bus.wdata;
               ebp_pkg::ADDR_DUTY: st_d.duty = bus.wdata;
               ebp_pkg::ADDR_PERIOD: st_d.period = bus.wdata;
               ebp_pkg::ADDR_TCTRL: st_d.tctrl = bus.wdata[2:0];
               ebp_pkg::ADDR_DELAY: st_d.delay = bus.wdata;
               ebp_pkg::ADDR_SHUT: st_d.shut = bus.wdata;
               ebp_pkg::ADDR_FLAG1: begin
                  st_d.timerFlag = bus.wdata[ebp_pkg::FLAG1_TIMER_BIT];
               end
               ebp_pkg::ADDR_FLAG2: begin
                  st_d.oscFailFlag =
                     bus.wdata[ebp_pkg::FLAG2_OSCFAIL_BIT];
               end
               ebp_pkg::ADDR_PINDIR: st_d.pinDir = bus.wdata[3:0];
               default: st_d.ctrl = st_d.ctrl;
            endcase
         end

         // Period timer: prescaler steps every clock while on.
         if (timerOn) begin
            if (stepEnd) begin
               st_d.pre = '0;
               st_d.timer = st_q.timer + 8'h01;
            end else begin
               st_d.pre = st_q.pre + 6'h01;
            end
            if (periodEnd) begin
               st_d.timer = '0;
               st_d.timerFlag = 1'b1;
               st_d.dutyLat = {st_q.duty,
                  st_q.ctrl[ebp_pkg::CTRL_DLSB_HI:
                            ebp_pkg::CTRL_DLSB_LO]};
               st_d.cfg = newCfg;
            end
         end else begin
            // A stopped timer keeps its count; the config follows at once
            // because no cycle is running to wait for.
            st_d.pre = '0;
            st_d.cfg = newCfg;
         end

         // Clock monitor failure: flag and internal oscillator mode.
         if (st_q.syncB[3]) begin
            st_d.oscFailFlag = 1'b1;
            st_d.oscMode = 1'b1;
         end

         // Shutdown event: set by the source, set wins over clear.
         if (srcActive) begin
            st_d.shut[ebp_pkg::SHUT_EVENT_BIT] = 1'b1;
         end else if (periodEnd
                      && st_q.delay[ebp_pkg::DELAY_RESTART_BIT]) begin
            st_d.shut[ebp_pkg::SHUT_EVENT_BIT] = 1'b0;
         end
         shutNow = st_q.shut[ebp_pkg::SHUT_EVENT_BIT];

         // Active levels of outputs a..d before polarity.
         case (st_q.cfg)
            ebp_pkg::CFG_SINGLE: begin
               act[0] = modAct;
            end
            ebp_pkg::CFG_FWD: begin
               // Forward: a on, d modulated, no dead band.
               act[0] = !leadPhase;
               act[2] = leadPhase;
               act[3] = modAct && !leadPhase;
            end
            ebp_pkg::CFG_REV: begin
               // Reverse: c on, b modulated, no dead band.
               act[2] = !leadPhase;
               act[0] = leadPhase;
               act[1] = modAct && !leadPhase;
            end
            ebp_pkg::CFG_HALF: begin
               act[0] = dbA;
               act[1] = dbB;
            end
            default: act = '0;
         endcase

         // Polarity: bit 1 inverts a and c, bit 0 inverts b and d.
         if (st_q.ctrl[3:2] == 2'h3) begin
            lvl[0] = act[0] ^ st_q.ctrl[1];
            lvl[2] = act[2] ^ st_q.ctrl[1];
            lvl[1] = act[1] ^ st_q.ctrl[0];
            lvl[3] = act[3] ^ st_q.ctrl[0];
         end

         // Shutdown overrides the pins with the programmed states.
         if (shutNow) begin
            lvl[0] = shutLvl(st_q.shut[ebp_pkg::SHUT_AC_LO +: 2]);
            lvl[2] = lvl[0];
            lvl[1] = shutLvl(st_q.shut[ebp_pkg::SHUT_BD_LO +: 2]);
            lvl[3] = lvl[1];
            rel[0] = st_q.shut[ebp_pkg::SHUT_AC_LO + 1];
            rel[2] = rel[0];
            rel[1] = st_q.shut[ebp_pkg::SHUT_BD_LO + 1];
            rel[3] = rel[1];
         end

         st_d.pinLvl = lvl;
         // A pin drives only when its direction bit makes it an output.
         st_d.pinOe = ~st_q.pinDir & ~rel;
      end
   end

   // State register; reset puts every pin back to input.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.period <= ebp_pkg::RST_PERIOD;
         st_q.pinDir <= ebp_pkg::RST_PINDIR;
         st_q.syncA <= 4'h1;
         st_q.syncB <= 4'h1;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops.
   assign rdata = st_q.rdata;
   assign intOscMode = st_q.oscMode;
   assign pins.lvl = st_q.pinLvl;
   assign pins.oe = st_q.pinOe;

endmodule

// ### include/ebp_pkg.sv
// Shared constants and carrier types for the enhanced bridge PWM block.
package ebp_pkg;

   // Register addresses on the plain register port.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_DUTY = 4'h1;
   localparam logic [3:0] ADDR_PERIOD = 4'h2;
   localparam logic [3:0] ADDR_TCTRL = 4'h3;
   localparam logic [3:0] ADDR_TIMER = 4'h4;
   localparam logic [3:0] ADDR_DELAY = 4'h5;
   localparam logic [3:0] ADDR_SHUT = 4'h6;
   localparam logic [3:0] ADDR_FLAG1 = 4'h7;
   localparam logic [3:0] ADDR_FLAG2 = 4'h8;
   localparam logic [3:0] ADDR_PINDIR = 4'h9;

   // Field positions inside the registers.
   localparam int CTRL_CFG_HI = 7;
   localparam int CTRL_CFG_LO = 6;
   localparam int CTRL_DIR_BIT = 7;
   localparam int CTRL_DLSB_HI = 5;
   localparam int CTRL_DLSB_LO = 4;
   localparam int TCTRL_ON_BIT = 2;
   localparam int DELAY_RESTART_BIT = 7;
   localparam int SHUT_EVENT_BIT = 7;
   localparam int SHUT_SRC_LO = 4;
   localparam int SHUT_AC_LO = 2;
   localparam int SHUT_BD_LO = 0;
   localparam int FLAG1_TIMER_BIT = 1;
   localparam int FLAG2_OSCFAIL_BIT = 7;

   // Values after reset.
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic [3:0] RST_PINDIR = 4'hf;

   // Output configuration encodings.
   localparam logic [1:0] CFG_SINGLE = 2'h0;
   localparam logic [1:0] CFG_FWD = 2'h1;
   localparam logic [1:0] CFG_HALF = 2'h2;
   localparam logic [1:0] CFG_REV = 2'h3;

   // Timing: one core clock is one oscillator period.
   localparam int CLK_NS = 10;
   localparam int TOSC_NS = 10;
   localparam int LEAD_TOSC = 4;
   localparam int LEAD_NS = LEAD_TOSC * TOSC_NS;
   localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRESCALE_MID = 4;
   localparam int PRESCALE_MAX = 16;
   localparam logic [5:0] PRE_LAST_1 = 6'(LEAD_CYC - 1);
   localparam logic [5:0] PRE_LAST_4 = 6'(LEAD_CYC * PRESCALE_MID - 1);
   localparam logic [5:0] PRE_LAST_16 = 6'(LEAD_CYC * PRESCALE_MAX - 1);

   // Register port request.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ebp_bus_t;

   // Bridge pin drive: level and output enable per pin, a..d as 0..3.
   typedef struct packed {
      logic [3:0] lvl;
      logic [3:0] oe;
   } ebp_pins_t;

   // State of the dead-band delay stage.
   typedef struct packed {
      logic [6:0] cnt;
      logic out;
   } ebp_db_t;

   // State of the main block.
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] duty;
      logic [7:0] period;
      logic [2:0] tctrl;
      logic [7:0] delay;
      logic [7:0] shut;
      logic timerFlag;
      logic oscFailFlag;
      logic [3:0] pinDir;
      logic [7:0] timer;
      logic [5:0] pre;
      logic [9:0] dutyLat;
      logic [1:0] cfg;
      logic [3:0] syncA;
      logic [3:0] syncB;
      logic oscMode;
      logic [7:0] rdata;
      logic [3:0] pinLvl;
      logic [3:0] pinOe;
   } ebp_state_t;

endpackage

// ### core/ebp_deadband.sv
`timescale 1ns/10ps
// Dead-band stage: the output follows a falling input at once and a
// rising input only after it has stayed high for the delay count.
module ebp_deadband #(
   parameter int DW = 7
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Control.
   input wire logic hold,
   input wire logic [DW-1:0] delay,
   // Signal path.
   input wire logic sigIn,
   output logic sigOut
);

   ebp_pkg::ebp_db_t st_q; // Registered state.
   ebp_pkg::ebp_db_t st_d; // Next state.

   // Count high time and release the output once the delay has passed.
   always_comb begin
      st_d = st_q;
      if (hold) begin
         st_d = st_q;
      end else if (!sigIn) begin
         st_d.cnt = '0;
         st_d.out = 1'b0;
      end else if (st_q.cnt >= 7'(delay)) begin
         st_d.out = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + 7'h01;
      end
   end

   // State register.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sigOut = st_q.out;

endmodule

// ### bench/ebp_top_asserts.sv
`timescale 1ns/10ps
// Port-level checks for the bridge PWM block.
module ebp_top_asserts (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire ebp_pkg::ebp_bus_t bus,
   input wire logic [7:0] rdata,
   // Shutdown and power inputs.
   input wire logic faultPin_n,
   input wire logic cmp1Out,
   input wire logic cmp2Out,
   input wire logic sleepReq,
   input wire logic clkFail,
   input wire logic intOscMode,
   // Bridge pins.
   input wire ebp_pkg::ebp_pins_t pins
);
   // Shadows of fields that software writes; hardware also sets the shut event bit.
   logic [7:0] perQ;
   logic [7:0] delQ;
   logic [7:0] shutQ;
   logic [2:0] tcQ;

   // Writes made outside sleep update the shadows.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         perQ <= ebp_pkg::RST_PERIOD;
         delQ <= 8'h00;
         shutQ <= 8'h00;
         tcQ <= 3'h0;
      end else if (bus.wr && !sleepReq) begin
         case (bus.addr)
            ebp_pkg::ADDR_PERIOD: perQ <= bus.wdata;
            ebp_pkg::ADDR_DELAY: delQ <= bus.wdata;
            ebp_pkg::ADDR_SHUT: shutQ <= bus.wdata;
            ebp_pkg::ADDR_TCTRL: tcQ <= bus.wdata[2:0];
            default: ;
         endcase
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // A fault held long enough to pass the synchroniser.
   sequence faultHeld;
      !faultPin_n [*8];
   endsequence

   AST_RST_IDLE: assert property (disable iff (1'b0) rst |=>
      pins.oe == 4'h0 && rdata == 8'h00 && !intOscMode)
      else $error("outputs not idle after reset");
   AST_OSC_HOLD: assert property (intOscMode |=> intOscMode)
      else $error("oscillator mode dropped");
   AST_OSC_SET: assert property (clkFail [*2] |-> ##[0:4] intOscMode)
      else $error("oscillator mode not entered");
   AST_SLEEP_FREEZE: assert property (sleepReq [*3] |-> $stable(pins))
      else $error("pins moved in sleep");
   AST_FAULT_OFF: assert property ((shutQ[6] && shutQ[3] && shutQ[1])
      and faultHeld |-> pins.oe == 4'h0)
      else $error("fault did not release pins");
   AST_RD_PERIOD: assert property (bus.rd &&
      bus.addr == ebp_pkg::ADDR_PERIOD |=> rdata == perQ)
      else $error("period readback wrong");
   AST_RD_TCTRL: assert property (bus.rd &&
      bus.addr == ebp_pkg::ADDR_TCTRL |=> rdata[2:0] == tcQ)
      else $error("timer control readback wrong");
   AST_RD_DELAY: assert property (bus.rd &&
      bus.addr == ebp_pkg::ADDR_DELAY |=> rdata == delQ)
      else $error("delay readback wrong");
endmodule

bind ebp_top ebp_top_asserts u_ebp_top_asserts (
   .core_clk(core_clk),
   .rst(rst),
   .bus(bus),
   .rdata(rdata),
   .faultPin_n(faultPin_n),
   .cmp1Out(cmp1Out),
   .cmp2Out(cmp2Out),
   .sleepReq(sleepReq),
   .clkFail(clkFail),
   .intOscMode(intOscMode),
   .pins(pins)
);

// ### bench/ebp_bridge_model.sv
`timescale 1ns/10ps
// Power switch drivers of an H-bridge with an over-current sense line.
module ebp_bridge_model (
   // Bridge pins seen by the drivers.
   input wire ebp_pkg::ebp_pins_t pins,
   // Commanded over-current event.
   input wire logic tripReq,
   // Fault sense back to the block.
   output logic faultPin_n
);
   // Undriven pins are pulled down, so only driven highs switch on.
   logic [3:0] on;
   assign on = pins.lvl & pins.oe;
   // Both switches of one leg on is a short; it trips the sense line.
   assign faultPin_n = !(tripReq || (on[0] && on[1]) || (on[2] && on[3]));
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
// Register-driven test of the bridge PWM block.
module tb_top;
   // Design stimulus and observation.
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   ebp_pkg::ebp_bus_t bus = '0;
   logic [7:0] rdata;
   logic faultPin_n;
   logic cmp1Out = 1'b0;
   logic cmp2Out = 1'b0;
   logic trip = 1'b0;
   logic sleepReq = 1'b0;
   logic clkFail = 1'b0;
   logic intOscMode;
   ebp_pkg::ebp_pins_t pins;
   // Active pin levels, and their value one sample earlier.
   logic [3:0] act;
   logic [3:0] pa;
   logic [7:0] rv;
   logic dr;
   int errorCnt = 0;
   int numChecks = 0;
   int n;
   int hc[4];

   assign act = pins.lvl & pins.oe;
   always #5 core_clk = ~core_clk;

   `define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin \
      errorCnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
      end end

   ebp_top u_ebp_top (.core_clk(core_clk), .rst(rst), .bus(bus),
      .rdata(rdata), .faultPin_n(faultPin_n), .cmp1Out(cmp1Out),
      .cmp2Out(cmp2Out), .sleepReq(sleepReq), .clkFail(clkFail),
      .intOscMode(intOscMode), .pins(pins));
   ebp_bridge_model u_ebp_bridge_model (.pins(pins), .tripReq(trip),
      .faultPin_n(faultPin_n));

   // Prints the verdict and ends the run.
   task stopTest();
      if (errorCnt == 0 && numChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One idle edge, then one write cycle.
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask

   // One read cycle; data is taken in the following cycle.
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      @(negedge core_clk);
      d = rdata;
   endtask

   // Read and compare.
   task rdc(input logic [3:0] a, input logic [7:0] e);
      rd(a, rv);
      `CHK(rv, e)
   endtask

   // Counts samples until a pin reaches a level; a long wait fails.
   task waitFor(input int b, input logic v);
      n = 0;
      do begin
         pa = act;
         @(negedge core_clk);
         n++;
         if (n > 1000) begin
            errorCnt++;
            stopTest();
         end
      end while (act[b] !== v);
   endtask

   // Counts active samples of every pin over a window.
   task cnt(input int cyc);
      hc = '{0, 0, 0, 0};
      repeat (cyc) begin
         @(negedge core_clk);
         for (int b = 0; b < 4; b++) begin
            if (act[b] === 1'b1) hc[b]++;
         end
      end
   endtask

   // Main sequence.
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rdc(ebp_pkg::ADDR_PERIOD, ebp_pkg::RST_PERIOD);
      rdc(ebp_pkg::ADDR_PINDIR, {4'h0, ebp_pkg::RST_PINDIR});
      rdc(ebp_pkg::ADDR_CTRL, ebp_pkg::RST_ZERO);
      rdc(4'hf, 8'h00);
      // Forward bridge, prescale 1, period 3 steps, duty 6 clocks.
      wr(ebp_pkg::ADDR_PERIOD, 8'h02);
      wr(ebp_pkg::ADDR_DUTY, 8'h01);
      wr(ebp_pkg::ADDR_CTRL, 8'h6c);
      rdc(ebp_pkg::ADDR_TIMER, 8'h00);
      wr(ebp_pkg::ADDR_TCTRL, 8'h04);
      // Pins are enabled only after a period has ended.
      n = 0;
      rv = 8'h00;
      while (rv[1] !== 1'b1 && n < 50) begin
         rd(ebp_pkg::ADDR_FLAG1, rv);
         n++;
      end
      `CHK(rv[1], 1'b1)
      wr(ebp_pkg::ADDR_PINDIR, 8'h00);
      wr(ebp_pkg::ADDR_SHUT, 8'h00);
      cnt(48);
      `CHK(hc[0], 48)
      `CHK(hc[1], 0)
      `CHK(hc[2], 0)
      `CHK(hc[3], 24)
      // Direction flips at prescale codes 0, 1 and 2.
      for (int i = 0; i < 3; i++) begin
         dr = (i != 1);
         wr(ebp_pkg::ADDR_TCTRL, 8'h04 | 8'(i));
         // Start the change early in a period so the lead window is whole.
         waitFor(dr ? 3 : 1, 1'b0);
         waitFor(dr ? 3 : 1, 1'b1);
         wr(ebp_pkg::ADDR_CTRL, dr ? 8'hec : 8'h6c);
         waitFor(dr ? 2 : 0, 1'b1);
         `CHK(pa[dr ? 0 : 2], 1'b1)
         `CHK(act[dr ? 0 : 2], 1'b0)
         waitFor(dr ? 1 : 3, 1'b1);
         `CHK(n, 4 << (2 * i))
      end
      wr(ebp_pkg::ADDR_TCTRL, 8'h04);
      rdc(ebp_pkg::ADDR_TCTRL, 8'h04);
      wr(ebp_pkg::ADDR_CTRL, 8'h6c);
      // Each shutdown source releases the pins while it is active.
      for (int i = 0; i < 3; i++) begin
         wr(ebp_pkg::ADDR_SHUT, 8'h0a | (8'h10 << i));
         {trip, cmp2Out, cmp1Out} <= 3'(1 << i);
         repeat (10) @(posedge core_clk);
         @(negedge core_clk);
         `CHK(pins.oe, 4'h0)
         rdc(ebp_pkg::ADDR_SHUT, 8'h8a | (8'h10 << i));
         {trip, cmp2Out, cmp1Out} <= 3'h0;
         repeat (6) @(posedge core_clk);
         wr(ebp_pkg::ADDR_SHUT, 8'h0a | (8'h10 << i));
         rdc(ebp_pkg::ADDR_SHUT, 8'h0a | (8'h10 << i));
         `CHK(pins.oe, 4'hf)
      end
      // Forced shutdown drives a,c high, then restarts at period end.
      wr(ebp_pkg::ADDR_SHUT, 8'h84);
      // The pins follow the event bit one clock after the write lands.
      repeat (2) @(negedge core_clk);
      `CHK(act, 4'h5)
      wr(ebp_pkg::ADDR_DELAY, 8'h80);
      repeat (40) @(posedge core_clk);
      rdc(ebp_pkg::ADDR_SHUT, 8'h04);
      // Half bridge: b rises a dead band after a falls.
      wr(ebp_pkg::ADDR_DELAY, 8'h05);
      rdc(ebp_pkg::ADDR_DELAY, 8'h05);
      wr(ebp_pkg::ADDR_CTRL, 8'hac);
      // Skip the drop out of forward drive and the first pulse of a.
      waitFor(0, 1'b0);
      waitFor(0, 1'b1);
      waitFor(0, 1'b0);
      waitFor(1, 1'b1);
      `CHK(n, 5)
      // Writes are ignored while asleep.
      @(posedge core_clk);
      sleepReq <= 1'b1;
      wr(ebp_pkg::ADDR_PERIOD, 8'h10);
      rdc(ebp_pkg::ADDR_PERIOD, 8'h02);
      repeat (10) @(posedge core_clk);
      sleepReq <= 1'b0;
      // Clock failure enters the internal oscillator mode.
      clkFail <= 1'b1;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      `CHK(intOscMode, 1'b1)
      rdc(ebp_pkg::ADDR_FLAG2, 8'h80);
      stopTest();
   end
endmodule
